// ===== src/asr_top.sv
// Converter sequence-slot selects, sampling time and result registers.
// Assumes an APB master on i_core_clk and a converter tick from core logic.
//
// The APB register port was left to the implementer.
`timescale 1ns/10ps
module asr_top
  import asr_pkg::*;
(
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Converter side
  input wire logic i_cnv_tick,
  input wire logic [15:0] i_adc_data,
  output asr_mux_t o_mux,
  output logic o_sampling,
  output logic o_busy,
  // Interrupt
  output logic o_irq
);
  logic [31:0] slots03_q;
  logic [31:0] slots47_q;
  logic [ASR_ST_W-1:0] sample_phase_length_q;
  logic start_q;
  logic [2:0] irq_stat_q;
  logic [2:0] irq_en_q;
  logic rd_pend_q;
  logic [31:0] rd_mux_q;
  logic acc_q;
  logic [31:0] res_rd_data;
  logic [ASR_SLOTS-1:0] res_valid;
  logic seq_busy;
  logic seq_sampling;
  logic [2:0] seq_slot;
  asr_result_t seq_res;
  logic seq_busy_q;
  logic [4:0] sel_code;
  logic [63:0] sel_all;

  // ------------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------------
  logic setup;
  logic wr_en;
  logic is_res;
  logic mapped;
  logic res_rd;
  logic [2:0] addr_slot;
  logic [11:0] res_off;
  always_comb begin
    setup = i_psel && !i_penable && !o_pready;
    wr_en = i_psel && i_penable && i_pwrite && o_pready;
    res_off = i_paddr - ASR_OFS_RESULT0;
    is_res = (i_paddr >= ASR_OFS_RESULT0) && (i_paddr <= ASR_OFS_RESULT7)
             && (i_paddr[1:0] == 2'b00);
    addr_slot = res_off[4:2];
    res_rd = setup && !i_pwrite && is_res;
    mapped = is_res || i_paddr == ASR_OFS_SLOTS_0_3
             || i_paddr == ASR_OFS_SLOTS_4_7 || i_paddr == ASR_OFS_SAMPLE
             || i_paddr == ASR_OFS_CTRL || i_paddr == ASR_OFS_IRQ_STAT
             || i_paddr == ASR_OFS_IRQ_EN || i_paddr == ASR_OFS_IRQ_CLR;
  end

  // One wait state: setup reads registers and store, the next edge
  // builds prdata and raises pready, which then stand for one cycle
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      acc_q <= 1'b0;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= ASR_ZERO;
      rd_pend_q <= 1'b0;
    end else begin
      acc_q <= setup;
      o_pready <= acc_q;
      o_pslverr <= acc_q && !mapped;
      rd_pend_q <= res_rd;
      if (acc_q && !i_pwrite) begin
        o_prdata <= rd_pend_q ? res_rd_data : rd_mux_q;
      end else begin
        o_prdata <= ASR_ZERO;
      end
    end
  end

  // Register read values captured in setup; results read from memory
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      rd_mux_q <= ASR_ZERO;
    end else begin
      unique case (i_paddr)
        ASR_OFS_SLOTS_0_3: rd_mux_q <= slots03_q;
        ASR_OFS_SLOTS_4_7: rd_mux_q <= slots47_q;
        ASR_OFS_SAMPLE: rd_mux_q <= {24'h000000, sample_phase_length_q};
        ASR_OFS_CTRL: rd_mux_q <= {30'h00000000, seq_busy_q, 1'b0};
        ASR_OFS_IRQ_STAT: rd_mux_q <= {29'h00000000, irq_stat_q};
        ASR_OFS_IRQ_EN: rd_mux_q <= {29'h00000000, irq_en_q};
        default: rd_mux_q <= ASR_ZERO;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Control registers
  // ------------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      slots03_q <= ASR_ZERO;
      slots47_q <= ASR_ZERO;
    end else if (wr_en && i_paddr == ASR_OFS_SLOTS_0_3) begin
      slots03_q <= i_pwdata & ASR_SLOT_MASK;
    end else if (wr_en && i_paddr == ASR_OFS_SLOTS_4_7) begin
      slots47_q <= i_pwdata & ASR_SLOT_MASK;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      sample_phase_length_q <= '0;
    end else if (wr_en && i_paddr == ASR_OFS_SAMPLE) begin
      sample_phase_length_q <= i_pwdata[ASR_ST_W-1:0];
    end
  end

  // Start pulse: write bit 0 of control; ignored while busy
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      start_q <= 1'b0;
      seq_busy_q <= 1'b0;
    end else begin
      start_q <= wr_en && i_paddr == ASR_OFS_CTRL && i_pwdata[0]
                 && !seq_busy;
      seq_busy_q <= seq_busy;
    end
  end

  // ------------------------------------------------------------------
  // Interrupts: 0 result written, 1 sequence done, 2 overwrite of unread
  // ------------------------------------------------------------------
  logic [2:0] irq_evt;
  always_comb begin
    irq_evt[0] = seq_res.wr;
    irq_evt[1] = seq_res.wr && seq_res.slot == 3'h7;
    irq_evt[2] = seq_res.wr && res_valid[seq_res.slot];
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      irq_stat_q <= '0;
      irq_en_q <= '0;
      o_irq <= 1'b0;
    end else begin
      if (wr_en && i_paddr == ASR_OFS_IRQ_EN) begin
        irq_en_q <= i_pwdata[2:0];
      end
      // Set wins over a clear in the same cycle
      if (wr_en && i_paddr == ASR_OFS_IRQ_CLR) begin
        irq_stat_q <= (irq_stat_q & ~i_pwdata[2:0]) | irq_evt;
      end else begin
        irq_stat_q <= irq_stat_q | irq_evt;
      end
      o_irq <= |(irq_stat_q & irq_en_q);
    end
  end

  // ------------------------------------------------------------------
  // Sequencer, result store and multiplexer selection
  // ------------------------------------------------------------------
  asr_sequencer u_seq (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_start(start_q),
    .i_cnv_tick(i_cnv_tick),
    .i_sample_phase_length(sample_phase_length_q),
    .i_adc_data(i_adc_data),
    .o_busy(seq_busy),
    .o_sampling(seq_sampling),
    .o_slot(seq_slot),
    .o_res(seq_res)
  );

  asr_result_mem #(.SLOTS(ASR_SLOTS)) u_mem (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_res(seq_res),
    .i_rd(res_rd),
    .i_rd_slot(addr_slot),
    .o_rd_data(res_rd_data),
    .o_valid(res_valid)
  );

  assign sel_all = {slots47_q, slots03_q};
  assign sel_code = sel_all[seq_slot*ASR_SEL_STRIDE +: ASR_SEL_W];

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_mux <= '{src: ASR_SRC_NONE, input_num: 4'h0};
      o_sampling <= 1'b0;
      o_busy <= 1'b0;
    end else begin
      o_sampling <= seq_sampling;
      o_busy <= seq_busy;
      if (!seq_busy) begin
        o_mux <= '{src: ASR_SRC_NONE, input_num: 4'h0};
      end else if (sel_code <= ASR_SEL_IN_MAX) begin
        o_mux <= '{src: ASR_SRC_INPUT, input_num: sel_code[3:0]};
      end else if (sel_code == ASR_SEL_GND) begin
        o_mux <= '{src: ASR_SRC_GND, input_num: 4'h0};
      end else if (sel_code == ASR_SEL_SUP) begin
        o_mux <= '{src: ASR_SRC_SUP, input_num: 4'h0};
      end else begin
        // Reserved and forbidden codes leave the multiplexer open
        o_mux <= '{src: ASR_SRC_NONE, input_num: 4'h0};
      end
    end
  end

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  // Multiplexer routing
  mux_input_a: assert property (@(posedge i_core_clk)
    disable iff (i_sys_rst)
    seq_busy && sel_code <= ASR_SEL_IN_MAX |=>
    o_mux.src == ASR_SRC_INPUT && o_mux.input_num == $past(sel_code[3:0]))
    else $error("input select not routed");
  mux_ground_a: assert property (@(posedge i_core_clk)
    disable iff (i_sys_rst)
    seq_busy && sel_code == ASR_SEL_GND |=> o_mux.src == ASR_SRC_GND)
    else $error("ground select not routed");
  mux_supply_a: assert property (@(posedge i_core_clk)
    disable iff (i_sys_rst)
    seq_busy && sel_code == ASR_SEL_SUP |=> o_mux.src == ASR_SRC_SUP)
    else $error("supply select not routed");
  reserved_code_a: assert property (@(posedge i_core_clk)
    disable iff (i_sys_rst)
    seq_busy && sel_code > ASR_SEL_IN_MAX && sel_code < ASR_SEL_GND
    |=> o_mux.src == ASR_SRC_NONE)
    else $error("reserved select drove the multiplexer");

  // Register writes and reads
  slot_write_a: assert property (@(posedge i_core_clk)
    disable iff (i_sys_rst)
    wr_en && i_paddr == ASR_OFS_SLOTS_4_7 |=>
    slots47_q == ($past(i_pwdata) & ASR_SLOT_MASK))
    else $error("slot select write lost");
  sample_write_a: assert property (@(posedge i_core_clk)
    disable iff (i_sys_rst)
    wr_en && i_paddr == ASR_OFS_SAMPLE |=>
    sample_phase_length_q == $past(i_pwdata[ASR_ST_W-1:0]))
    else $error("sampling time write lost");
  result_read_a: assert property (@(posedge i_core_clk)
    disable iff (i_sys_rst)
    res_rd |-> ##2 o_pready && o_prdata[30:16] == 15'h0000
    && o_prdata[ASR_VALID_BIT] == $past(res_valid[addr_slot], 2))
    else $error("result word malformed");

  // Bus answer
  pready_pulse_a: assert property (@(posedge i_core_clk)
    disable iff (i_sys_rst)
    o_pready |=> !o_pready)
    else $error("pready held past one cycle");
  prdata_idle_a: assert property (@(posedge i_core_clk)
    disable iff (i_sys_rst)
    !o_pready |-> o_prdata == ASR_ZERO)
    else $error("read data outside the answer cycle");
  slverr_map_a: assert property (@(posedge i_core_clk)
    disable iff (i_sys_rst)
    o_pslverr |-> o_pready)
    else $error("slave error without pready");

  // Interrupt status
  irq_set_wins_a: assert property (@(posedge i_core_clk)
    disable iff (i_sys_rst)
    irq_evt[0] |=> irq_stat_q[0])
    else $error("result event lost");
  irq_clear_a: assert property (@(posedge i_core_clk)
    disable iff (i_sys_rst)
    wr_en && i_paddr == ASR_OFS_IRQ_CLR && i_pwdata[1] && !irq_evt[1]
    |=> !irq_stat_q[1])
    else $error("status clear ignored");
  irq_level_a: assert property (@(posedge i_core_clk)
    disable iff (i_sys_rst)
    |(irq_stat_q & irq_en_q) |=> o_irq)
    else $error("interrupt not raised");
  irq_low_a: assert property (@(posedge i_core_clk)
    disable iff (i_sys_rst)
    !(|(irq_stat_q & irq_en_q)) |=> !o_irq)
    else $error("interrupt raised with nothing pending");
endmodule

// ===== src/asr_pkg.sv
// Package for the converter sequence and result register block.
// Assumes a 32-bit APB slave and a single core clock domain.
package asr_pkg;
  // ------------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------------
  localparam logic [11:0] ASR_OFS_SLOTS_0_3 = 12'h004;
  localparam logic [11:0] ASR_OFS_SLOTS_4_7 = 12'h008;
  localparam logic [11:0] ASR_OFS_SAMPLE = 12'h020;
  localparam logic [11:0] ASR_OFS_RESULT0 = 12'h030;
  localparam logic [11:0] ASR_OFS_RESULT7 = 12'h04C;
  localparam logic [11:0] ASR_OFS_CTRL = 12'h080;
  localparam logic [11:0] ASR_OFS_IRQ_STAT = 12'h090;
  localparam logic [11:0] ASR_OFS_IRQ_EN = 12'h094;
  localparam logic [11:0] ASR_OFS_IRQ_CLR = 12'h098;
  // ------------------------------------------------------------------
  // Field layout and codes
  // ------------------------------------------------------------------
  localparam int ASR_SLOTS = 8;
  localparam int ASR_SEL_W = 5;
  localparam int ASR_SEL_STRIDE = 8;
  localparam int ASR_ST_W = 8;
  localparam int ASR_RES_W = 16;
  localparam int ASR_VALID_BIT = 31;
  localparam logic [31:0] ASR_SLOT_MASK = 32'h1F1F1F1F;
  localparam logic [31:0] ASR_ZERO = 32'h00000000;
  localparam logic [4:0] ASR_SEL_IN_MAX = 5'h0B;
  localparam logic [4:0] ASR_SEL_GND = 5'h10;
  localparam logic [4:0] ASR_SEL_SUP = 5'h11;
  // Sampling lasts setting + 1.5 converter clocks: counted in half periods
  localparam logic [9:0] ASR_HALF_EXTRA = 10'h003;
  // Conversion after sampling, in converter clocks (plain default)
  localparam logic [7:0] ASR_CONV_CLKS = 8'h0C;

  typedef enum logic [1:0] {
    ASR_SRC_INPUT,
    ASR_SRC_GND,
    ASR_SRC_SUP,
    ASR_SRC_NONE
  } asr_src_t;

  // Selection handed to the analog multiplexer
  typedef struct packed {
    asr_src_t src;
    logic [3:0] input_num;
  } asr_mux_t;

  // Result write from the converter
  typedef struct packed {
    logic wr;
    logic [2:0] slot;
    logic [15:0] value;
  } asr_result_t;
endpackage

// ===== src/asr_result_mem.sv
// Eight per-slot result words with valid flags, registered read data.
// Assumes a write and a read-clear may hit one slot in the same cycle.
`timescale 1ns/10ps
module asr_result_mem
  import asr_pkg::*;
#(
  parameter int SLOTS = ASR_SLOTS
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  // Write side
  input wire asr_result_t i_res,
  // Read side
  input wire logic i_rd,
  input wire logic [2:0] i_rd_slot,
  output logic [31:0] o_rd_data,
  output logic [SLOTS-1:0] o_valid
);
  initial begin
    if (SLOTS != 8) $error("asr_result_mem: SLOTS must be 8");
  end

  logic [ASR_RES_W-1:0] value_q [SLOTS];
  logic [SLOTS-1:0] valid_q;

  // ------------------------------------------------------------------
  // Per-slot storage
  // ------------------------------------------------------------------
  for (genvar s = 0; s < SLOTS; s++) begin : g_slot
    always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
        value_q[s] <= '0;
        valid_q[s] <= 1'b0;
      end else if (i_res.wr && i_res.slot == 3'(s)) begin
        value_q[s] <= i_res.value;
        valid_q[s] <= 1'b1;
      end else if (i_rd && i_rd_slot == 3'(s)) begin
        valid_q[s] <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_rd_data <= ASR_ZERO;
    end else if (i_rd) begin
      o_rd_data <= {valid_q[i_rd_slot], 15'h0000, value_q[i_rd_slot]};
    end
  end

  assign o_valid = valid_q;

  read_clears_a: assert property (@(posedge i_core_clk)
    disable iff (i_sys_rst)
    i_rd && !(i_res.wr && i_res.slot == i_rd_slot)
    |=> !valid_q[$past(i_rd_slot)])
    else $error("valid flag survived a read");
  write_sets_a: assert property (@(posedge i_core_clk)
    disable iff (i_sys_rst)
    i_res.wr |=> valid_q[$past(i_res.slot)]
    && value_q[$past(i_res.slot)] == $past(i_res.value))
    else $error("result write not stored");
endmodule

// ===== src/asr_sequencer.sv
// Walks slots 0..7: sample phase timing then conversion, then result write.
// Assumes the analog converter hands back data on o_res write cycles.
`timescale 1ns/10ps
module asr_sequencer
  import asr_pkg::*;
(
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  // Control
  input wire logic i_start,
  input wire logic i_cnv_tick,
  input wire logic [7:0] i_sample_phase_length,
  input wire logic [15:0] i_adc_data,
  // Status
  output logic o_busy,
  output logic o_sampling,
  output logic [2:0] o_slot,
  output asr_result_t o_res
);
  typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONV} asr_seq_state_t;
  asr_seq_state_t state_q;
  logic [9:0] half_q;
  logic [7:0] conv_q;

  // ------------------------------------------------------------------
  // Sequence engine
  // ------------------------------------------------------------------
  // i_cnv_tick marks each converter half period
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      state_q <= ST_IDLE;
      half_q <= '0;
      conv_q <= '0;
      o_slot <= '0;
      o_res <= '0;
    end else begin
      o_res.wr <= 1'b0;
      unique case (state_q)
        ST_IDLE: begin
          if (i_start) begin
            state_q <= ST_SAMPLE;
            o_slot <= '0;
            half_q <= '0;
          end
        end
        ST_SAMPLE: begin
          if (i_cnv_tick) begin
            half_q <= half_q + 10'h001;
            if (half_q + 10'h001 ==
                {1'b0, i_sample_phase_length, 1'b0} + ASR_HALF_EXTRA) begin
              state_q <= ST_CONV;
              conv_q <= '0;
            end
          end
        end
        ST_CONV: begin
          if (i_cnv_tick) begin
            conv_q <= conv_q + 8'h01;
            if (conv_q == {ASR_CONV_CLKS[6:0], 1'b0} - 8'h01) begin
              o_res <= '{wr: 1'b1, slot: o_slot, value: i_adc_data};
              half_q <= '0;
              if (o_slot == 3'h7) begin
                state_q <= ST_IDLE;
              end else begin
                o_slot <= o_slot + 3'h1;
                state_q <= ST_SAMPLE;
              end
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  assign o_busy = (state_q != ST_IDLE);
  assign o_sampling = (state_q == ST_SAMPLE);

  sample_len_a: assert property (@(posedge i_core_clk)
    disable iff (i_sys_rst)
    $rose(state_q == ST_CONV) |->
    $past(half_q) + 10'h001 ==
    {1'b0, i_sample_phase_length, 1'b0} + ASR_HALF_EXTRA)
    else $error("sample phase length wrong");
endmodule

// ===== tb/asr_adc_model.sv
// Converter model: half-period ticks and a result made from the select.
// Assumes the block raises i_sampling during each slot's sample phase.
`timescale 1ns/10ps
module asr_adc_model
  import asr_pkg::*;
(
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  // Block side
  input wire asr_mux_t i_mux,
  input wire logic i_sampling,
  output logic o_cnv_tick,
  output logic [15:0] o_adc_data,
  output logic [15:0] o_last_len
);
  asr_mux_t held_q;
  logic [15:0] len_q;
  logic [15:0] val;

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) o_cnv_tick <= 1'b0;
    else o_cnv_tick <= ~o_cnv_tick;
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sampling) held_q <= i_mux;
  end

  // Input number only means something for external inputs
  assign val = {4'hA, 2'h0, held_q.src, 4'h0,
    (held_q.src == ASR_SRC_INPUT) ? held_q.input_num : 4'h0};
  // Line is not settled while the input is still being sampled
  assign o_adc_data = i_sampling ? ~val : val;

  // Length of the last sample phase in core cycles
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      len_q <= 16'h0000;
      o_last_len <= 16'h0000;
    end else if (i_sampling) begin
      len_q <= len_q + 16'h0001;
    end else if (len_q != 16'h0000) begin
      o_last_len <= len_q;
      len_q <= 16'h0000;
    end
  end
endmodule

// ===== tb/asr_top_tb_top.sv
// Testbench for the sequence select and result register block.
// Assumes a converter model on the far side and an APB master task here.
`timescale 1ns/10ps
module asr_top_tb_top
  import asr_pkg::*;
;
  logic core_clk, sys_rst, psel, penable, pwrite, pready, pslverr;
  logic cnv_tick, sampling, busy, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] adc_data, last_len;
  logic err;
  asr_mux_t mux;
  int failures = 0;
  int check_count = 0;
  int cycles = 0;
  // Only codes 0x00-0x11 are ever written
  logic [4:0] cfg_a [8] = '{5'h00, 5'h03, 5'h07, 5'h0A,
    5'h05, 5'h0B, 5'h10, 5'h11};
  logic [4:0] cfg_b [8] = '{5'h01, 5'h02, 5'h04, 5'h06,
    5'h08, 5'h09, 5'h0C, 5'h11};

  asr_top dut (.i_core_clk(core_clk), .i_sys_rst(sys_rst), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_cnv_tick(cnv_tick), .i_adc_data(adc_data),
    .o_mux(mux), .o_sampling(sampling), .o_busy(busy), .o_irq(irq));
  asr_adc_model adc (.i_core_clk(core_clk), .i_sys_rst(sys_rst),
    .i_mux(mux), .i_sampling(sampling), .o_cnv_tick(cnv_tick),
    .o_adc_data(adc_data), .o_last_len(last_len));

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // ------------------------------------------------------------------
  // Bus and check tasks
  // ------------------------------------------------------------------
  function automatic logic [15:0] exp_val(input logic [4:0] c);
    logic [1:0] s;
    s = (c <= 5'h0B) ? 2'h0 : (c == 5'h10) ? 2'h1 : (c == 5'h11) ? 2'h2 : 2'h3;
    return {4'hA, 2'h0, s, 4'h0, (c <= 5'h0B) ? c[3:0] : 4'h0};
  endfunction

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge core_clk);
    end
    chk("pready", 32'h1, {31'h0, pready});
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rreg(input string nm, input logic [11:0] a,
                      input logic [31:0] e);
    apb(1'b0, a, ASR_ZERO);
    chk(nm, e, rd);
  endtask

  task automatic setcfg(input logic [4:0] c [8]);
    logic [31:0] w0, w1;
    w0 = ASR_ZERO;
    w1 = ASR_ZERO;
    for (int i = 0; i < 4; i++) begin
      w0[8*i +: 5] = c[i];
      w1[8*i +: 5] = c[i+4];
    end
    apb(1'b1, ASR_OFS_SLOTS_0_3, w0 | ~ASR_SLOT_MASK);
    apb(1'b1, ASR_OFS_SLOTS_4_7, w1 | ~ASR_SLOT_MASK);
    rreg("slots 0-3", ASR_OFS_SLOTS_0_3, w0);
    rreg("slots 4-7", ASR_OFS_SLOTS_4_7, w1);
  endtask

  task automatic run_seq(input logic [7:0] s);
    int n;
    n = 0;
    apb(1'b1, ASR_OFS_SAMPLE, {24'hFFFFFF, s});
    rreg("sampling", ASR_OFS_SAMPLE, {24'h000000, s});
    apb(1'b1, ASR_OFS_CTRL, 32'h00000001);
    repeat (4) @(posedge core_clk);
    while (busy !== 1'b0 && n < 5000) begin
      n++;
      @(posedge core_clk);
    end
    chk("busy end", 32'h0, {31'h0, busy});
    chk("sample length", {22'h0, s, 2'h0} + 32'h6, {16'h0, last_len});
  endtask

  task automatic chkres(input logic [4:0] c [8], input logic v);
    for (int y = 0; y < 8; y++) begin
      rreg("result", ASR_OFS_RESULT0 + 12'(4*y),
        {v, 15'h0000, exp_val(c[y])});
    end
  endtask

  task automatic print_verdict();
    $display("Checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      print_verdict();
    end
  end

  // ------------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------------
  initial begin
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = ASR_ZERO;
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'b0;
    chk("mux idle", 32'h3, {30'h0, mux.src});
    for (int y = 0; y < 8; y++) begin
      rreg("reset result", ASR_OFS_RESULT0 + 12'(4*y), ASR_ZERO);
    end
    rreg("reset slots 0-3", ASR_OFS_SLOTS_0_3, ASR_ZERO);
    rreg("reset slots 4-7", ASR_OFS_SLOTS_4_7, ASR_ZERO);
    rreg("reset sampling", ASR_OFS_SAMPLE, ASR_ZERO);
    rreg("unmapped", 12'h0FC, ASR_ZERO);
    chk("unmapped error", 32'h1, {31'h0, err});
    $display("Test reset done");
    apb(1'b1, ASR_OFS_IRQ_EN, 32'h00000007);
    setcfg(cfg_a);
    run_seq(8'h02);
    chkres(cfg_a, 1'b1);
    chkres(cfg_a, 1'b0);
    rreg("irq status", ASR_OFS_IRQ_STAT, 32'h00000003);
    chk("irq raised", 32'h1, {31'h0, irq});
    apb(1'b1, ASR_OFS_IRQ_CLR, 32'h00000003);
    rreg("irq cleared", ASR_OFS_IRQ_STAT, ASR_ZERO);
    chk("irq low", 32'h0, {31'h0, irq});
    $display("Test sequence done");
    apb(1'b1, ASR_OFS_IRQ_EN, ASR_ZERO);
    setcfg(cfg_b);
    run_seq(8'h00);
    chk("irq masked", 32'h0, {31'h0, irq});
    rreg("masked status", ASR_OFS_IRQ_STAT, 32'h00000003);
    apb(1'b1, ASR_OFS_IRQ_EN, 32'h00000007);
    repeat (2) @(posedge core_clk);
    chk("irq unmasked", 32'h1, {31'h0, irq});
    $display("Test mask done");
    run_seq(8'h00);
    rreg("overwrite status", ASR_OFS_IRQ_STAT, 32'h00000007);
    apb(1'b1, ASR_OFS_RESULT0, ASR_ZERO);
    chkres(cfg_b, 1'b1);
    apb(1'b1, ASR_OFS_IRQ_CLR, 32'h00000007);
    rreg("final status", ASR_OFS_IRQ_STAT, ASR_ZERO);
    $display("Test overwrite done");
    print_verdict();
  end
endmodule
